// ### hdl/seq_params.svh
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// ==========================================================================
// Sizes
`define NUM_DET          8
`define DET_W            4
`define CODE_W           4
`define IRQ_W            4
`define TMR_CYC_W        24
`define TMR_TICK_W       7

// ==========================================================================
// Timing
`define CLK_HZ           40000000
`define TICK_MS          100
`define PASS_TIME_MS     3000
`define TICK_CYCLES      ((`CLK_HZ / 1000) * `TICK_MS)
`define PASS_TICKS       (`PASS_TIME_MS / `TICK_MS)
`define DELAY_MIN_DS     7'h02
`define DELAY_MAX_DS     7'h78
`define RST_DELAY_DS     7'h32

// ==========================================================================
// Register map
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_CLEAR    8'h0C
`define OFS_IRQ_ENABLE   8'h10
`define CTRL_DELAY_LSB   0
`define CTRL_DELAY_MSB   6
`define CTRL_COUNT_LSB   8
`define CTRL_COUNT_MSB   11
`define CTRL_TAR_BIT     16
`define STS_STATE_LSB    0
`define STS_STATE_MSB    2
`define STS_LEFT_LSB     4
`define STS_LEFT_MSB     7
`define STS_RIGHT_LSB    8
`define STS_RIGHT_MSB    11
`define STS_INST_BIT     12
`define STS_TIMED_BIT    13
`define STS_BLANK_BIT    14
`define STS_FLED_BIT     15
`define STS_CBYP_BIT     16
`define IRQ_BYPASS_BIT   0
`define IRQ_FAULT_BIT    1
`define IRQ_TIMED_BIT    2
`define IRQ_PASS_BIT     3
`define RST_DET_COUNT    4'h8
`define WORD_SIZE        3'h2

// ==========================================================================
// Display codes
`define CODE_BYPASS      4'h8
`define CODE_PASS        4'h0
`define CODE_LOW_SENS    4'h2
`define DET_FIRST        4'h1

`endif

// ### hdl/sequencer_pkg.sv
`include "seq_params.svh"

package sequencer_pkg;

   // ==========================================================================
   // Types
   typedef enum logic [2:0]
   {
      ST_NORMAL = 3'b001,
      ST_BYPASS = 3'b010,
      ST_FAULT  = 3'b100
   } mode_state_t;

   typedef struct packed
   {
      logic [`TMR_CYC_W-1:0]  cyc;
      logic [`TMR_TICK_W-1:0] ticks;
      logic                   done;
   } timer_state_t;

   typedef struct packed
   {
      mode_state_t            state;
      logic                   test_q;
      logic                   sel_q;
      logic                   rst_q;
      logic [`DET_W-1:0]      sel_det;
      logic                   fault_valid;
      logic [`DET_W-1:0]      fault_det;
      logic [`CODE_W-1:0]     fault_code;
      logic                   fault_led;
      logic                   fault_relay;
      logic                   disp_blank;
      logic [`DET_W-1:0]      left;
      logic [`CODE_W-1:0]     right;
      logic                   relay_inst;
      logic                   relay_timed;
      logic                   contact_bypass;
      logic [`TMR_TICK_W-1:0] delay_ds;
      logic [`DET_W-1:0]      det_count;
      logic                   tar_fitted;
      logic [`IRQ_W-1:0]      irq_sts;
      logic [`IRQ_W-1:0]      irq_en;
      logic                   irq;
      logic                   wr_pend;
      logic [7:0]             wr_addr;
      logic [31:0]            hrdata;
      logic                   hreadyout;
      logic                   hresp;
   } seq_state_t;

endpackage

// ### hdl/timer_if.sv
`timescale 1ns/100ps
`include "seq_params.svh"

interface timer_if;
   logic                   run;
   logic [`TMR_TICK_W-1:0] limit;
   logic                   done;

   modport ctrl (output run, output limit, input done);
   modport tmr  (input run, input limit, output done);
endinterface

// ### hdl/tick_timer.sv
`timescale 1ns/100ps
`include "seq_params.svh"

module tick_timer #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control
   timer_if.tmr      tif
);
   import sequencer_pkg::*;

   timer_state_t s_r;
   timer_state_t s_nxt;

   // ==========================================================================
   // Elapsed time in ticks, cleared whenever run drops
   always_comb
   begin
      s_nxt = s_r;
      if (!tif.run)
      begin
         s_nxt.cyc   = '0;
         s_nxt.ticks = '0;
         s_nxt.done  = 1'b0;
      end
      else
      begin
         if (s_r.cyc == `TMR_CYC_W'(TICK_CYCLES - 1))
         begin
            s_nxt.cyc = '0;
            // Saturate so a long hold never wraps back to not-done
            if (s_r.ticks != '1)
               s_nxt.ticks = s_r.ticks + `TMR_TICK_W'(1);
         end
         else
            s_nxt.cyc = s_r.cyc + `TMR_CYC_W'(1);
         s_nxt.done = (s_r.ticks >= tif.limit);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign tif.done = s_r.done;

endmodule // tick_timer

// ### hdl/bypass_test_seq.sv
`timescale 1ns/100ps
`include "seq_params.svh"

// Behaviour
// - Entering bypass lights the fault lamp, shows the selected detector left and 8 right.
// - In bypass a held test button energizes the immediate relay and its lamp at once.
// - While the test persists the delayed relay and lamp follow after the set delay.
// - About three seconds into a held test the right display turns from 8 to 0 on pass.
// - With arc rejection fitted and the self-check passing the right display stays at 8 during a held test.
// - Any other right code during a test is a fault; a failed self-check shows 2.
// - Releasing the test button or losing UV drops both relays and both lamps.
// - Each select press in bypass steps to the next detector and updates the left display.
// - In bypass the relay contacts are electrically bypassed so loads stay untouched.
// - In bypass real UV lights the immediate lamp first and the delayed lamp after the delay.
// - Normal resumes only with the switch at normal and a reset press, blanking all.
// - Code 2 is reported for a detector when its response is below the threshold or when it is missing.
// - The delay is adjustable from 0.2 to 12 s and is 5 s out of reset.
// - The delayed relay needs unbroken UV for the whole delay; a gap restarts timing.
// - The first fault is latched on the displays until bypass is entered.
// - More detectors configured than present gives a fault naming the missing one, code 2.
module bypass_test_seq #(
   parameter int NUM_DET     = `NUM_DET,
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Front panel controls
   input  wire logic                  bypass_sw,
   input  wire logic                  test_btn,
   input  wire logic                  select_btn,
   input  wire logic                  reset_btn,
   // Detector inputs
   input  wire logic [NUM_DET-1:0]    uv_in,
   input  wire logic [NUM_DET-1:0]    det_present,
   input  wire logic [NUM_DET-1:0]    sens_low,
   input  wire logic                  optical_self_check,
   // Relays and lamps
   output logic                       relay_instant,
   output logic                       relay_timed,
   output logic                       led_instant,
   output logic                       led_timed,
   output logic                       contact_bypass,
   output logic                       fault_relay,
   output logic                       fault_led,
   // Displays
   output logic                       display_blank,
   output logic [`DET_W-1:0]          display_left,
   output logic [`CODE_W-1:0]         display_right,
   // Interrupt
   output logic                       irq
);
   import sequencer_pkg::*;

   seq_state_t             s_r;
   seq_state_t             s_nxt;
   logic                   bypass;
   logic                   stim;
   logic                   test_run;
   logic                   sel_edge;
   logic                   rst_edge;

   logic                   found;
   logic [`DET_W-1:0]      found_det;
   logic                   addr_ok;
   logic [31:0]            rd_mux;
   logic [`IRQ_W-1:0]      ev;
   logic [`IRQ_W-1:0]      clr;
   logic [`TMR_TICK_W-1:0] dly_wr;

   timer_if dly_if ();
   timer_if pass_if ();

   // ==========================================================================
   // Timers
   tick_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_delay_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (dly_if)
   );

   tick_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_pass_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (pass_if)
   );

   assign bypass = (s_r.state == ST_BYPASS);
   // Any stimulus gap drops run and clears elapsed time
   assign stim   = (bypass && test_btn) || (|uv_in);
   assign test_run = bypass && test_btn;

   assign dly_if.run    = stim;
   assign dly_if.limit  = s_r.delay_ds;
   assign pass_if.run   = test_run;
   assign pass_if.limit = `TMR_TICK_W'(`PASS_TICKS);

   // Idle low as the buttons are
   assign sel_edge = select_btn && !s_r.sel_q;
   assign rst_edge = reset_btn && !s_r.rst_q;

   // ==========================================================================
   // First faulty detector within the configured count
   always_comb
   begin
      found     = 1'b0;
      found_det = `DET_FIRST;
      for (int i = 0; i < NUM_DET; i++)
      begin
         if (!found && (i < int'(s_r.det_count)))
         begin
            if (!det_present[i] || sens_low[i])
            begin
               found     = 1'b1;
               found_det = `DET_W'(i + 1);
            end
         end
      end
   end

   // ==========================================================================
   // Register read mux
   assign addr_ok = hsel && htrans[1] && hready && (hsize == `WORD_SIZE);

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (haddr[7:0] == `OFS_CTRL)
      begin
         rd_mux[`CTRL_DELAY_MSB:`CTRL_DELAY_LSB] = s_r.delay_ds;
         rd_mux[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB] = s_r.det_count;
         rd_mux[`CTRL_TAR_BIT]                   = s_r.tar_fitted;
      end
      else if (haddr[7:0] == `OFS_STATUS)
      begin
         rd_mux[`STS_STATE_MSB:`STS_STATE_LSB] = s_r.state;
         rd_mux[`STS_LEFT_MSB:`STS_LEFT_LSB]   = s_r.left;
         rd_mux[`STS_RIGHT_MSB:`STS_RIGHT_LSB] = s_r.right;
         rd_mux[`STS_INST_BIT]                 = s_r.relay_inst;
         rd_mux[`STS_TIMED_BIT]                = s_r.relay_timed;
         rd_mux[`STS_BLANK_BIT]                = s_r.disp_blank;
         rd_mux[`STS_FLED_BIT]                 = s_r.fault_led;
         rd_mux[`STS_CBYP_BIT]                 = s_r.contact_bypass;
      end
      else if (haddr[7:0] == `OFS_IRQ_STATUS)
         rd_mux[`IRQ_W-1:0] = s_r.irq_sts;
      else if (haddr[7:0] == `OFS_IRQ_ENABLE)
         rd_mux[`IRQ_W-1:0] = s_r.irq_en;
      else
         rd_mux = 32'h0000_0000;
   end

   // ==========================================================================
   // Next state
   always_comb
   begin
      s_nxt  = s_r;
      ev     = '0;
      clr    = '0;
      dly_wr = hwdata[`CTRL_DELAY_MSB:`CTRL_DELAY_LSB];

      s_nxt.test_q    = test_btn;
      s_nxt.sel_q     = select_btn;
      s_nxt.rst_q     = reset_btn;

      s_nxt.hreadyout = 1'b1;
      s_nxt.hresp     = 1'b0;

      // Bus: capture address phase, act on write in data phase
      s_nxt.wr_pend = addr_ok && hwrite;
      s_nxt.wr_addr = haddr[7:0];
      if (addr_ok && !hwrite)
         s_nxt.hrdata = rd_mux;
      if (s_r.wr_pend)
      begin
         if (s_r.wr_addr == `OFS_CTRL)
         begin
            // Clamp keeps the delay inside its adjustable span
            if (dly_wr < `DELAY_MIN_DS)
               s_nxt.delay_ds = `DELAY_MIN_DS;
            else if (dly_wr > `DELAY_MAX_DS)
               s_nxt.delay_ds = `DELAY_MAX_DS;
            else
               s_nxt.delay_ds = dly_wr;
            if (hwdata[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB] != '0)
               s_nxt.det_count = hwdata[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB];
            s_nxt.tar_fitted = hwdata[`CTRL_TAR_BIT];
         end
         else if (s_r.wr_addr == `OFS_IRQ_CLEAR)
            clr = hwdata[`IRQ_W-1:0];
         else if (s_r.wr_addr == `OFS_IRQ_ENABLE)
            s_nxt.irq_en = hwdata[`IRQ_W-1:0];
      end

      // Relays follow the stimulus in every mode
      s_nxt.relay_inst  = stim;
      s_nxt.relay_timed = stim && dly_if.done;
      if (stim && dly_if.done && !s_r.relay_timed)
         ev[`IRQ_TIMED_BIT] = 1'b1;

      case (s_r.state)
         ST_NORMAL, ST_FAULT:
         begin
            if (bypass_sw)
            begin
               s_nxt.state       = ST_BYPASS;
               s_nxt.fault_valid = 1'b0;
               ev[`IRQ_BYPASS_BIT] = 1'b1;
            end
            else if (!s_r.fault_valid && found)
            begin
               // Later faults never overwrite the first
               s_nxt.state       = ST_FAULT;
               s_nxt.fault_valid = 1'b1;
               s_nxt.fault_det   = found_det;
               s_nxt.fault_code  = `CODE_LOW_SENS;
               ev[`IRQ_FAULT_BIT] = 1'b1;
            end
         end
         ST_BYPASS:
         begin
            if (!bypass_sw && rst_edge)
               s_nxt.state = ST_NORMAL;

            // Wraps at the configured count
            if (sel_edge)
            begin
               if (s_r.sel_det >= s_r.det_count)
                  s_nxt.sel_det = `DET_FIRST;
               else
                  s_nxt.sel_det = s_r.sel_det + `DET_W'(1);
            end

            if (test_run && pass_if.done && !s_r.tar_fitted && optical_self_check
                && (s_r.right != `CODE_PASS))
               ev[`IRQ_PASS_BIT] = 1'b1;
            if (test_run && pass_if.done && !optical_self_check
                && (s_r.right != `CODE_LOW_SENS))
               ev[`IRQ_FAULT_BIT] = 1'b1;
         end
         default:
            s_nxt.state = ST_NORMAL;
      endcase

      // Panel outputs from the next mode
      if (s_nxt.state == ST_BYPASS)
      begin
         s_nxt.fault_led      = 1'b1;
         s_nxt.fault_relay    = 1'b0;
         s_nxt.disp_blank     = 1'b0;
         s_nxt.contact_bypass = 1'b1;
         s_nxt.left           = s_nxt.sel_det;
         s_nxt.right          = `CODE_BYPASS;
         if (test_run && pass_if.done)
         begin
            if (!optical_self_check)
               s_nxt.right = `CODE_LOW_SENS;
            else if (!s_r.tar_fitted)
               s_nxt.right = `CODE_PASS;
         end
      end
      else if (s_nxt.state == ST_FAULT)
      begin
         s_nxt.fault_led      = 1'b1;
         s_nxt.fault_relay    = 1'b0;
         s_nxt.disp_blank     = 1'b0;
         s_nxt.contact_bypass = 1'b0;
         s_nxt.left           = s_nxt.fault_det;
         s_nxt.right          = s_nxt.fault_code;
      end
      else
      begin
         s_nxt.fault_led      = 1'b0;
         s_nxt.fault_relay    = 1'b1;
         s_nxt.disp_blank     = 1'b1;
         s_nxt.contact_bypass = 1'b0;
         s_nxt.left           = '0;
         s_nxt.right          = '0;
      end

      // Set wins over a clear in the same cycle
      s_nxt.irq_sts = (s_r.irq_sts & ~clr) | ev;
      s_nxt.irq     = |(s_nxt.irq_sts & s_nxt.irq_en);
   end

   // ==========================================================================
   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r                <= '0;
         s_r.state          <= ST_NORMAL;
         s_r.sel_det        <= `DET_FIRST;
         s_r.fault_relay    <= 1'b1;
         s_r.disp_blank     <= 1'b1;
         s_r.delay_ds       <= `RST_DELAY_DS;
         s_r.det_count      <= `RST_DET_COUNT;
         s_r.hreadyout      <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   // ==========================================================================
   // Outputs
   assign hrdata         = s_r.hrdata;
   assign hreadyout      = s_r.hreadyout;
   assign hresp          = s_r.hresp;

   assign relay_instant  = s_r.relay_inst;
   assign relay_timed    = s_r.relay_timed;
   // Lamps share the relay drives
   assign led_instant    = s_r.relay_inst;
   assign led_timed      = s_r.relay_timed;
   assign contact_bypass = s_r.contact_bypass;
   assign fault_relay    = s_r.fault_relay;
   assign fault_led      = s_r.fault_led;

   assign display_blank  = s_r.disp_blank;
   assign display_left   = s_r.left;
   assign display_right  = s_r.right;

   assign irq            = s_r.irq;

endmodule // bypass_test_seq

// ### testbench/panel_det_model.sv
`timescale 1ns/100ps

module panel_det_model #(
   parameter int NUM_DET = 8
) (
   // Scenario controls
   input  wire logic [3:0]         lamp,
   input  wire logic [NUM_DET-1:0] missing,
   input  wire logic [NUM_DET-1:0] dirty,
   input  wire logic               check_ok,
   // Detector lines
   output logic [NUM_DET-1:0]      uv_in,
   output logic [NUM_DET-1:0]      det_present,
   output logic [NUM_DET-1:0]      sens_low,
   output logic                    optical_self_check
);
   // ==========================================================================
   // Detectors
   // Lamp names one detector; a missing head sees nothing
   assign uv_in = (lamp == 4'h0) ? '0 : ((NUM_DET'(1) << (lamp - 4'h1)) & ~missing);
   assign det_present = ~missing;
   assign sens_low = dirty & ~missing;
   assign optical_self_check = check_ok;
endmodule // panel_det_model

// ### testbench/seq_monitor.sv
`timescale 1ns/100ps
`include "seq_params.svh"

module seq_monitor #(
   parameter int NUM_DET     = 8,
   parameter int TICK_CYCLES = 10
) (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire logic               bypass_sw,
   input wire logic               test_btn,
   input wire logic               select_btn,
   input wire logic               reset_btn,
   input wire logic [NUM_DET-1:0] uv_in,
   input wire logic               relay_instant,
   input wire logic               relay_timed,
   input wire logic               led_instant,
   input wire logic               led_timed,
   input wire logic               contact_bypass,
   input wire logic               fault_led,
   input wire logic               display_blank,
   input wire logic [3:0]         display_left,
   input wire logic [3:0]         display_right
);
   // Loose bounds: tick phase may shift the timer by a tick
   localparam int MIN_TIMED = TICK_CYCLES;
   localparam int MIN_PASS  = 29 * TICK_CYCLES;
   logic [31:0] run_r;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ==========================================================================
   // Helper
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         run_r <= '0;
      else
         run_r <= relay_instant ? run_r + 32'h0000_0001 : '0;
   end

   sequence s_bypass_idle;
      bypass_sw && !test_btn && (uv_in == '0);
   endsequence

   // ==========================================================================
   // Assertions
   a_bypass_entry: assert property (s_bypass_idle ##1 s_bypass_idle |=> fault_led
      && contact_bypass && !display_blank && display_right == `CODE_BYPASS)
      else $error("bypass display or lamps wrong");
   a_instant_follow: assert property (relay_instant ==
      $past((contact_bypass && test_btn) || (|uv_in)))
      else $error("instant relay not following stimulus");
   a_lamps_match: assert property (led_instant == relay_instant && led_timed == relay_timed)
      else $error("lamp differs from relay");
   a_timed_needs_inst: assert property (relay_timed |-> relay_instant)
      else $error("timed relay without instant relay");
   a_timed_run_length: assert property ($rose(relay_timed) |-> run_r >= MIN_TIMED)
      else $error("timed relay too early");
   a_pass_delay: assert property (contact_bypass && $changed(display_right)
      && display_right == `CODE_PASS |-> run_r >= MIN_PASS)
      else $error("pass code too early");
   a_select_step: assert property (contact_bypass && bypass_sw && $rose(select_btn)
      |=> display_left == $past(display_left) + 4'h1 || display_left == `DET_FIRST)
      else $error("select did not step");
   a_leave_bypass: assert property (contact_bypass && !bypass_sw && $rose(reset_btn)
      |=> display_blank && !fault_led && !contact_bypass)
      else $error("normal mode not resumed");
   a_stay_bypass: assert property (contact_bypass && (bypass_sw || !$rose(reset_btn))
      |=> contact_bypass)
      else $error("bypass left without switch and reset");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
endmodule // seq_monitor

bind bypass_test_seq seq_monitor #(.NUM_DET(NUM_DET), .TICK_CYCLES(TICK_CYCLES)) seq_monitor_inst (
   .hclk, .hresetn, .hreadyout, .hresp, .bypass_sw, .test_btn, .select_btn, .reset_btn,
   .uv_in, .relay_instant, .relay_timed, .led_instant, .led_timed, .contact_bypass,
   .fault_led, .display_blank, .display_left, .display_right);

// ### testbench/tb_bypass_test_seq.sv
`timescale 1ns/100ps
`include "seq_params.svh"

module tb_bypass_test_seq;
   localparam int TK = 10;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        bypass_sw, test_btn, select_btn, reset_btn, check_ok, optical_self_check;
   logic [3:0]  lamp, display_left, display_right;
   logic [7:0]  missing, dirty, uv_in, det_present, sens_low;
   logic        relay_instant, relay_timed, led_instant, led_timed;
   logic        contact_bypass, fault_relay, fault_led, display_blank;
   int          n_mismatch, check_count, n, tt;

   bypass_test_seq #(.NUM_DET(8), .TICK_CYCLES(TK)) bypass_test_seq_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .bypass_sw, .test_btn, .select_btn, .reset_btn, .uv_in,
      .det_present, .sens_low, .optical_self_check, .relay_instant, .relay_timed,
      .led_instant, .led_timed, .contact_bypass, .fault_relay, .fault_led, .display_blank,
      .display_left, .display_right, .irq);
   panel_det_model #(.NUM_DET(8)) panel_det_model_inst (
      .lamp, .missing, .dirty, .check_ok, .uv_in, .det_present, .sens_low, .optical_self_check);

   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // ==========================================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask

   // Single word transfer; read data kept in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= 32'(a);
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      #1;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      chk({display_blank, fault_relay, irq}, 3'b110);
      bus(1'b0, `OFS_CTRL, '0);
      chk(rd, 32'h0000_0832);
      bus(1'b0, 8'h20, '0);
      chk(rd, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_bypass;
      bypass_sw <= 1'b1;
      cyc(2);
      chk({fault_led, contact_bypass, display_blank, display_left, display_right}, 11'h618);
      chk(irq, 1'b0);
      bus(1'b0, `OFS_IRQ_STATUS, '0);
      chk(rd, 32'h0000_0001);
      bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0001);
      cyc(2);
      chk(irq, 1'b1);
      bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_0001);
      cyc(2);
      chk(irq, 1'b0);
      $display("bypass test done");
   endtask

   task automatic t_select;
      bus(1'b1, `OFS_CTRL, 32'h0000_0300);
      bus(1'b0, `OFS_CTRL, '0);
      chk(rd, 32'h0000_0302);
      bus(1'b1, `OFS_CTRL, 32'h0000_007F);
      bus(1'b0, `OFS_CTRL, '0);
      chk(rd, 32'h0000_0378);
      bus(1'b1, `OFS_CTRL, 32'h0000_0302);
      for (int i = 0; i < 3; i++)
      begin
         select_btn <= 1'b1;
         cyc(1);
         select_btn <= 1'b0;
         cyc(1);
         chk(display_left, 4'((i + 1) % 3 + 1));
      end
      $display("select test done");
   endtask

   task automatic t_test;
      test_btn <= 1'b1;
      cyc(1);
      chk(relay_instant && led_instant, 1'b1);
      n = 0;
      tt = 0;
      while (display_right !== `CODE_PASS && n < 1000)
      begin
         cyc(1);
         n++;
         if (tt == 0 && relay_timed === 1'b1)
            tt = n;
      end
      chk(tt >= 2 * TK && tt <= 2 * TK + 4, 1'b1);
      chk(n >= 30 * TK - 2 && n <= 30 * TK + 4, 1'b1);
      test_btn <= 1'b0;
      cyc(1);
      chk({relay_instant, relay_timed, led_instant, led_timed, display_right}, 8'h08);
      $display("manual test done");
   endtask

   task automatic t_tar;
      bus(1'b1, `OFS_CTRL, 32'h0001_0302);
      test_btn <= 1'b1;
      cyc(30 * TK + 20);
      chk(display_right, `CODE_BYPASS);
      test_btn <= 1'b0;
      bus(1'b1, `OFS_CTRL, 32'h0000_0302);
      check_ok <= 1'b0;
      test_btn <= 1'b1;
      cyc(30 * TK + 20);
      chk(display_right, `CODE_LOW_SENS);
      test_btn <= 1'b0;
      check_ok <= 1'b1;
      cyc(2);
      $display("arc and self check test done");
   endtask

   task automatic t_uv;
      lamp <= 4'h1;
      cyc(12);
      chk({relay_instant, relay_timed}, 2'b10);
      lamp <= 4'h0;
      cyc(1);
      lamp <= 4'h1;
      n = 0;
      while (relay_timed !== 1'b1 && n < 1000)
      begin
         cyc(1);
         n++;
      end
      chk(n >= 2 * TK, 1'b1);
      lamp <= 4'h0;
      cyc(1);
      chk({relay_instant, relay_timed}, 2'b00);
      $display("uv test done");
   endtask

   task automatic t_leave;
      bypass_sw <= 1'b0;
      cyc(4);
      chk(contact_bypass, 1'b1);
      reset_btn <= 1'b1;
      cyc(1);
      reset_btn <= 1'b0;
      chk({display_blank, fault_led, contact_bypass}, 3'b100);
      cyc(3);
      chk(fault_led, 1'b0);
      $display("leave test done");
   endtask

   task automatic t_fault;
      missing <= 8'h02;
      cyc(3);
      chk({fault_led, fault_relay, display_left, display_right}, 10'h222);
      dirty <= 8'h01;
      reset_btn <= 1'b1;
      cyc(3);
      reset_btn <= 1'b0;
      chk(display_left, 4'h2);
      bypass_sw <= 1'b1;
      cyc(2);
      chk(display_right, `CODE_BYPASS);
      $display("fault test done");
   endtask

   // ==========================================================================
   // Main
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = `WORD_SIZE;
      {bypass_sw, test_btn, select_btn, reset_btn, lamp, missing, dirty} = '0;
      check_ok = 1'b1;
      n_mismatch = 0;
      check_count = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(1);
      t_reset();
      t_bypass();
      t_select();
      t_test();
      t_tar();
      t_uv();
      t_leave();
      t_fault();
      wrap_up();
   end

   // Whole run is about a thousand cycles
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      wrap_up();
   end
endmodule // tb_bypass_test_seq
